// ---- core/ssc_pkg.sv ----
/*
  Constants, register map and state codes of the stop-mode standby controller.
  Assumes a 200 MHz system clock that stands in for the main oscillator clock.
*/
package ssc_pkg;

  // ---------------------------------------------------------------------------
  // Clock and timing
  // ---------------------------------------------------------------------------
  localparam int unsigned CLK_HZ          = 200_000_000;
  // Settle after a reset wake, in main clock periods, as a power of two
  localparam int unsigned RST_SETTLE_LOG2 = 18;
  localparam int unsigned RST_SETTLE_CYC  = 1 << RST_SETTLE_LOG2;

  // ---------------------------------------------------------------------------
  // Register bus
  // ---------------------------------------------------------------------------
  localparam int unsigned ADDR_W = 5;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned BE_W   = 4;

  localparam logic [ADDR_W-1:0] OFS_SETTLE   = 5'h00;
  localparam logic [ADDR_W-1:0] OFS_PCFG     = 5'h04;
  localparam logic [ADDR_W-1:0] OFS_STATUS   = 5'h08;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 5'h0c;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 5'h10;

  // osc_settle_select: wait = 2**(base + sel), sel above the maximum is clamped
  localparam int unsigned       SEL_W   = 3;
  localparam logic [SEL_W-1:0]  SEL_RST = 3'h4;
  localparam logic [SEL_W-1:0]  SEL_MAX = 3'h4;

  // Peripheral clock-source configuration bits
  localparam int unsigned      PCFG_W      = 4;
  localparam int unsigned      PCFG_T8_EXT = 0;
  localparam int unsigned      PCFG_WT_SUB = 1;
  localparam int unsigned      PCFG_SIO_EXT = 2;
  localparam int unsigned      PCFG_AUTO_EN = 3;
  localparam logic [PCFG_W-1:0] PCFG_RST   = 4'h0;

  // Event bits, shared by the sticky status and the mask register
  localparam int unsigned    EV_W         = 6;
  localparam int unsigned    EV_STOP      = 0;
  localparam int unsigned    EV_HALT      = 1;
  localparam int unsigned    EV_WAKE_IRQ  = 2;
  localparam int unsigned    EV_WAKE_TEST = 3;
  localparam int unsigned    EV_WAKE_RST  = 4;
  localparam int unsigned    EV_REFUSED   = 5;
  localparam logic [EV_W-1:0] EV_RST      = 6'h00;

  // Status word: state code in the low bits, then the subsystem clock flag
  localparam int unsigned ST_STATE_W = 5;
  localparam int unsigned ST_SUB_CLK = 5;

  // ---------------------------------------------------------------------------
  // State and wake cause
  // ---------------------------------------------------------------------------
  typedef enum logic [4:0] {
    SSC_RUN    = 5'h01,
    SSC_STOP   = 5'h02,
    SSC_HALT   = 5'h04,
    SSC_SETTLE = 5'h08,
    SSC_RHOLD  = 5'h10
  } ssc_state_t;

  typedef enum logic [2:0] {
    SSC_CAUSE_IRQ  = 3'h1,
    SSC_CAUSE_TEST = 3'h2,
    SSC_CAUSE_RST  = 3'h4
  } ssc_cause_t;

endpackage

// ---- core/ssc_timer_if.sv ----
/*
  Handshake between the controller and its settle timer.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
interface ssc_timer_if #(parameter int unsigned CNT_W = 19);
  logic             start;
  logic [CNT_W-1:0] cycles;
  logic             busy;
  logic             done;

  modport ctrl  (output start, output cycles, input busy, input done);
  modport timer (input start, input cycles, output busy, output done);
endinterface

// ---- core/ssc_sync.sv ----
/*
  Two-flop synchroniser for pin-level inputs.
  Assumes inputs are slow levels; a pulse shorter than one clock can be missed.
*/
`timescale 1ns/1ps
module ssc_sync #(
  parameter int unsigned W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         clk,
  input  wire logic         arst_n,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end else begin
      meta_q <= din;
      sync_q <= meta_q;
    end
  end

  assign dout = sync_q;
endmodule

// ---- core/ssc_settle_timer.sv ----
/*
  Oscillation-settle down counter.
  Assumes start is a one-cycle pulse with cycles of at least one.
*/
`timescale 1ns/1ps
module ssc_settle_timer #(
  parameter int unsigned CNT_W = 19
) (
  input  wire logic clk,
  input  wire logic arst_n,
  ssc_timer_if.timer tif
);
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic             busy_q, busy_d;
  logic             done_q, done_d;

  always_comb begin
    cnt_d  = cnt_q;
    busy_d = busy_q;
    done_d = 1'b0;
    if (tif.start) begin
      cnt_d  = tif.cycles - CNT_W'(1);
      busy_d = 1'b1;
    end else if (busy_q) begin
      if (cnt_q == '0) begin
        busy_d = 1'b0;
        done_d = 1'b1;
      end else begin
        cnt_d = cnt_q - CNT_W'(1);
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q  <= '0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      busy_q <= busy_d;
      done_q <= done_d;
    end
  end

  assign tif.busy = busy_q;
  assign tif.done = done_q;
endmodule

// ---- core/ssc_top.sv ----
/*
  Stop-mode standby controller: entry on the stop instruction, peripheral and
  bus-pin freeze while stopped, wake by interrupt, test input or reset pin,
  then an oscillation-settle wait.
  Assumes the CPU core, interrupt controller and bus unit share clk; the reset
  pin and the subsystem clock presence come from pins and are synchronised.
*/
// The placing of the registers and the Avalon-MM slave port were decided locally.
`timescale 1ns/1ps
//
// Function
// - Stop instruction enters the stop state
// - Entry only while running main clock
// - Ground main oscillator input while stopped
// - Pending unmasked interrupt falls to halt
// - Only main oscillator stops, subclock runs
// - 8-bit timers run on external input
// - Watch timer runs only on subclock
// - Serial runs on external clock only
// - Interrupt zero off, one-three stay on
// - Expansion bus lines parked while stopped
// - Upper address and port latches held
// - Interrupt, test or reset end stop
// - Interrupt wake: settle, vector or continue
// - Test wake: settle, then next instruction
// - Reset wake: settle, then reset processing
module ssc_top
  import ssc_pkg::*;
#(
  parameter int unsigned NIRQ            = 8,
  parameter int unsigned PORT_W          = 8,
  parameter int unsigned CNT_W           = 19,
  parameter int unsigned SETTLE_BASE_LOG2 = 12,
  parameter int unsigned RST_SETTLE_CYCLES = ssc_pkg::RST_SETTLE_CYC
) (
  input  wire logic                       clk,
  input  wire logic                       arst_n,
  input  wire logic [ssc_pkg::ADDR_W-1:0] avs_address,
  input  wire logic                       avs_read,
  input  wire logic                       avs_write,
  input  wire logic [ssc_pkg::BE_W-1:0]   avs_byteenable,
  input  wire logic [ssc_pkg::DATA_W-1:0] avs_writedata,
  output logic      [ssc_pkg::DATA_W-1:0] avs_readdata,
  output logic                            avs_waitrequest,
  output logic                            irq,
  input  wire logic                       cpu_stop_exec,
  input  wire logic                       cpu_on_main_clk,
  input  wire logic                       cpu_ack_enable,
  input  wire logic [NIRQ-1:0]            irq_req,
  input  wire logic [NIRQ-1:0]            irq_mask,
  input  wire logic                       test_req,
  input  wire logic                       test_mask,
  input  wire logic                       ext_reset_n,
  input  wire logic                       sub_clk_present,
  input  wire logic [7:0]                 cpu_ad_out,
  input  wire logic                       cpu_ad_oe,
  input  wire logic [7:0]                 cpu_upper_addr,
  input  wire logic                       cpu_addr_latch_strobe,
  input  wire logic                       cpu_rd_n,
  input  wire logic                       cpu_wr_n,
  input  wire logic                       cpu_wait_oe,
  input  wire logic [PORT_W-1:0]          cpu_port_latch,
  output logic      [7:0]                 mux_addr_data_lines_o,
  output logic                            mux_addr_data_lines_oe,
  output logic      [7:0]                 upper_addr_lines,
  output logic                            addr_latch_strobe,
  output logic                            rd_n,
  output logic                            wr_n,
  output logic                            wait_oe,
  output logic      [PORT_W-1:0]          port_out,
  output logic                            main_osc_enable,
  output logic                            main_osc_input_ground,
  output logic                            sub_osc_enable,
  output logic                            cpu_clk_enable,
  output logic                            timer16_run,
  output logic                            watchdog_run,
  output logic                            adc_run,
  output logic                            timer8_run,
  output logic                            watch_timer_run,
  output logic                            serial_run,
  output logic                            auto_txrx_run,
  output logic                            ext_irq_zero_enable,
  output logic                            ext_irq_one_to_three_enable,
  output logic                            wake_vector,
  output logic                            wake_continue,
  output logic                            wake_reset
);
  import ssc_pkg::*;

  if (CNT_W < 2 || CNT_W > 31 || SETTLE_BASE_LOG2 + SEL_MAX >= CNT_W ||
      RST_SETTLE_CYCLES < 1 || RST_SETTLE_CYCLES >= (1 << CNT_W) || NIRQ < 1) begin : g_chk
    $error("ssc_top: parameters out of range");
  end

  // ---------------------------------------------------------------------------
  // Pin synchronisers and settle timer
  // ---------------------------------------------------------------------------
  logic rst_pin_n;
  logic sub_ok;

  ssc_sync #(.W(2), .RST_VAL(2'h1)) u_sync (
    .clk    (clk),
    .arst_n (arst_n),
    .din    ({sub_clk_present, ext_reset_n}),
    .dout   ({sub_ok, rst_pin_n})
  );

  ssc_timer_if #(.CNT_W(CNT_W)) tif ();

  ssc_settle_timer #(.CNT_W(CNT_W)) u_timer (
    .clk    (clk),
    .arst_n (arst_n),
    .tif    (tif)
  );

  // ---------------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------------
  logic [SEL_W-1:0]  sel_q, sel_d;
  logic [PCFG_W-1:0] pcfg_q, pcfg_d;
  logic [EV_W-1:0]   ist_q, ist_d;
  logic [EV_W-1:0]   imask_q, imask_d;
  logic [EV_W-1:0]   snap_q, snap_d;
  logic [DATA_W-1:0] rdata_q, rdata_d;
  logic              ack_q, ack_d;
  logic [EV_W-1:0]   ev;
  logic              req;
  logic              accept;

  assign req             = avs_read | avs_write;
  assign avs_waitrequest = req & ~ack_q;
  assign accept          = req & ack_q;
  assign avs_readdata    = rdata_q;
  assign irq             = |(ist_q & imask_q);

  ssc_state_t state_q, state_d;

  function automatic logic [CNT_W-1:0] settle_cycles(input logic [SEL_W-1:0] sel);
    logic [SEL_W-1:0] s;
    s = (sel > SEL_MAX) ? SEL_MAX : sel;
    return CNT_W'(1) << (SETTLE_BASE_LOG2 + int'(s));
  endfunction

  always_comb begin
    ack_d   = req & ~ack_q;
    rdata_d = rdata_q;
    snap_d  = snap_q;
    sel_d   = sel_q;
    pcfg_d  = pcfg_q;
    imask_d = imask_q;
    // Read data is fixed one cycle ahead of acceptance, unmapped reads give zero
    if (req && !ack_q && avs_read) begin
      rdata_d = '0;
      snap_d  = '0;
      case (avs_address)
        OFS_SETTLE:   rdata_d[SEL_W-1:0] = sel_q;
        OFS_PCFG:     rdata_d[PCFG_W-1:0] = pcfg_q;
        OFS_STATUS: begin
          rdata_d[ST_STATE_W-1:0] = state_q;
          rdata_d[ST_SUB_CLK]     = sub_ok;
        end
        OFS_IRQ_STAT: begin
          rdata_d[EV_W-1:0] = ist_q;
          snap_d            = ist_q;
        end
        OFS_IRQ_MASK: rdata_d[EV_W-1:0] = imask_q;
        default:      rdata_d = '0;
      endcase
    end
    if (accept && avs_write && avs_byteenable[0]) begin
      case (avs_address)
        OFS_SETTLE:   sel_d   = avs_writedata[SEL_W-1:0];
        OFS_PCFG:     pcfg_d  = avs_writedata[PCFG_W-1:0];
        OFS_IRQ_MASK: imask_d = avs_writedata[EV_W-1:0];
        default:      sel_d   = sel_q;
      endcase
    end
    // Only bits that were returned are cleared, so a new event always survives
    ist_d = ist_q | ev;
    if (accept && avs_read && avs_address == OFS_IRQ_STAT) begin
      ist_d = (ist_q & ~snap_q) | ev;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ack_q   <= 1'b0;
      rdata_q <= '0;
      snap_q  <= EV_RST;
      sel_q   <= SEL_RST;
      pcfg_q  <= PCFG_RST;
      ist_q   <= EV_RST;
      imask_q <= EV_RST;
    end else begin
      ack_q   <= ack_d;
      rdata_q <= rdata_d;
      snap_q  <= snap_d;
      sel_q   <= sel_d;
      pcfg_q  <= pcfg_d;
      ist_q   <= ist_d;
      imask_q <= imask_d;
    end
  end

  // ---------------------------------------------------------------------------
  // Standby sequencer
  // ---------------------------------------------------------------------------
  ssc_cause_t cause_q, cause_d;
  logic       irq_pend;
  logic       test_pend;
  logic       vec_q, vec_d;
  logic       cont_q, cont_d;
  logic       rstp_q, rstp_d;

  assign irq_pend  = |(irq_req & ~irq_mask);
  assign test_pend = test_req & ~test_mask;

  always_comb begin
    state_d    = state_q;
    cause_d    = cause_q;
    tif.start  = 1'b0;
    tif.cycles = settle_cycles(sel_q);
    ev         = '0;
    vec_d      = 1'b0;
    cont_d     = 1'b0;
    rstp_d     = 1'b0;
    case (state_q)
      SSC_RUN: begin
        if (cpu_stop_exec) begin
          if (!cpu_on_main_clk) begin
            ev[EV_REFUSED] = 1'b1;
          end else if (irq_pend) begin
            state_d        = SSC_HALT;
            cause_d        = SSC_CAUSE_IRQ;
            tif.start      = 1'b1;
            ev[EV_HALT]    = 1'b1;
          end else begin
            state_d        = SSC_STOP;
            ev[EV_STOP]    = 1'b1;
          end
        end
      end
      SSC_STOP: begin
        if (!rst_pin_n) begin
          state_d = SSC_RHOLD;
        end else if (irq_pend) begin
          state_d   = SSC_SETTLE;
          cause_d   = SSC_CAUSE_IRQ;
          tif.start = 1'b1;
        end else if (test_pend) begin
          state_d   = SSC_SETTLE;
          cause_d   = SSC_CAUSE_TEST;
          tif.start = 1'b1;
        end
      end
      SSC_RHOLD: begin
        if (rst_pin_n) begin
          state_d    = SSC_SETTLE;
          cause_d    = SSC_CAUSE_RST;
          tif.start  = 1'b1;
          tif.cycles = CNT_W'(RST_SETTLE_CYCLES);
        end
      end
      SSC_HALT, SSC_SETTLE: begin
        if (!rst_pin_n) begin
          state_d = SSC_RHOLD;
        end else if (tif.done) begin
          state_d = SSC_RUN;
          case (cause_q)
            SSC_CAUSE_IRQ: begin
              vec_d           = cpu_ack_enable;
              cont_d          = ~cpu_ack_enable;
              ev[EV_WAKE_IRQ] = 1'b1;
            end
            SSC_CAUSE_TEST: begin
              cont_d           = 1'b1;
              ev[EV_WAKE_TEST] = 1'b1;
            end
            default: begin
              rstp_d          = 1'b1;
              ev[EV_WAKE_RST] = 1'b1;
            end
          endcase
        end
      end
      default: state_d = SSC_RUN;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= SSC_RUN;
      cause_q <= SSC_CAUSE_IRQ;
      vec_q   <= 1'b0;
      cont_q  <= 1'b0;
      rstp_q  <= 1'b0;
    end else begin
      state_q <= state_d;
      cause_q <= cause_d;
      vec_q   <= vec_d;
      cont_q  <= cont_d;
      rstp_q  <= rstp_d;
    end
  end

  assign wake_vector   = vec_q;
  assign wake_continue = cont_q;
  assign wake_reset    = rstp_q;

  // ---------------------------------------------------------------------------
  // Clock and peripheral gating
  // ---------------------------------------------------------------------------
  logic deep;
  assign deep = (state_q == SSC_STOP) || (state_q == SSC_RHOLD) || (state_q == SSC_SETTLE);

  assign main_osc_input_ground = (state_q == SSC_STOP) || (state_q == SSC_RHOLD);
  assign main_osc_enable = ~main_osc_input_ground;
  assign sub_osc_enable  = 1'b1;
  assign cpu_clk_enable  = (state_q == SSC_RUN);
  assign timer16_run     = ~deep;
  assign watchdog_run    = ~deep;
  assign adc_run         = ~deep;
  assign timer8_run      = ~deep | pcfg_q[PCFG_T8_EXT];
  assign watch_timer_run = ~deep | (sub_ok & pcfg_q[PCFG_WT_SUB]);
  assign serial_run      = ~deep | pcfg_q[PCFG_SIO_EXT];
  assign auto_txrx_run   = ~deep & pcfg_q[PCFG_AUTO_EN];
  assign ext_irq_zero_enable         = ~deep;
  assign ext_irq_one_to_three_enable = 1'b1;

  // ---------------------------------------------------------------------------
  // External bus and port pins
  // ---------------------------------------------------------------------------
  logic [7:0]        ad_q, ad_d;
  logic              ad_oe_q, ad_oe_d;
  logic [7:0]        up_q, up_d;
  logic              addr_latch_strobe_q, addr_latch_strobe_d;
  logic              rd_n_q, rd_n_d;
  logic              wr_n_q, wr_n_d;
  logic              wt_oe_q, wt_oe_d;
  logic [PORT_W-1:0] port_q, port_d;
  logic              hold;

  // Halt keeps the CPU clock off too, so its bus must be parked as well
  assign hold = (state_q != SSC_RUN) || (state_d != SSC_RUN);

  always_comb begin
    ad_d    = cpu_ad_out;
    ad_oe_d = cpu_ad_oe;
    up_d    = cpu_upper_addr;
    addr_latch_strobe_d  = cpu_addr_latch_strobe;
    rd_n_d  = cpu_rd_n;
    wr_n_d  = cpu_wr_n;
    wt_oe_d = cpu_wait_oe;
    port_d  = cpu_port_latch;
    if (hold) begin
      ad_d    = ad_q;
      ad_oe_d = 1'b0;
      addr_latch_strobe_d  = 1'b0;
      rd_n_d  = 1'b1;
      wr_n_d  = 1'b1;
      wt_oe_d = 1'b0;
      up_d    = up_q;
      port_d  = port_q;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ad_q    <= 8'h00;
      ad_oe_q <= 1'b0;
      up_q    <= 8'h00;
      addr_latch_strobe_q  <= 1'b0;
      rd_n_q  <= 1'b1;
      wr_n_q  <= 1'b1;
      wt_oe_q <= 1'b0;
      port_q  <= '0;
    end else begin
      ad_q    <= ad_d;
      ad_oe_q <= ad_oe_d;
      up_q    <= up_d;
      addr_latch_strobe_q  <= addr_latch_strobe_d;
      rd_n_q  <= rd_n_d;
      wr_n_q  <= wr_n_d;
      wt_oe_q <= wt_oe_d;
      port_q  <= port_d;
    end
  end

  assign mux_addr_data_lines_o  = ad_q;
  assign mux_addr_data_lines_oe = ad_oe_q;
  assign upper_addr_lines       = up_q;
  assign addr_latch_strobe      = addr_latch_strobe_q;
  assign rd_n                   = rd_n_q;
  assign wr_n                   = wr_n_q;
  assign wait_oe                = wt_oe_q;
  assign port_out               = port_q;

endmodule

// ---- verification/ssc_properties.sv ----
/*
  Port-level checker for the stop-mode standby controller.
  Assumes one clock domain.
*/
`timescale 1ns/1ps
module ssc_properties #(
  parameter int unsigned NIRQ   = 8,
  parameter int unsigned PORT_W = 8
) (
  input wire logic              clk,
  input wire logic              arst_n,
  input wire logic              cpu_stop_exec,
  input wire logic              cpu_on_main_clk,
  input wire logic              cpu_ack_enable,
  input wire logic [NIRQ-1:0]   irq_req,
  input wire logic [NIRQ-1:0]   irq_mask,
  input wire logic              mux_addr_data_lines_oe,
  input wire logic [7:0]        upper_addr_lines,
  input wire logic              addr_latch_strobe,
  input wire logic              rd_n,
  input wire logic              wr_n,
  input wire logic              wait_oe,
  input wire logic [PORT_W-1:0] port_out,
  input wire logic              main_osc_enable,
  input wire logic              main_osc_input_ground,
  input wire logic              sub_osc_enable,
  input wire logic              cpu_clk_enable,
  input wire logic              timer16_run,
  input wire logic              watchdog_run,
  input wire logic              adc_run,
  input wire logic              ext_irq_zero_enable,
  input wire logic              ext_irq_one_to_three_enable,
  input wire logic              wake_vector,
  input wire logic              wake_continue,
  input wire logic              wake_reset
);
  // -------------------------------------------------------------------------
  // Properties
  // -------------------------------------------------------------------------
  wire pend = |(irq_req & ~irq_mask);
  wire go   = cpu_stop_exec & cpu_clk_enable;
  wire gnd  = main_osc_input_ground;
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  property p_stop; go && cpu_on_main_clk && !pend |=> gnd && !main_osc_enable; endproperty
  a_stop: assert property (p_stop) else $error("stop not entered");
  property p_ref; go && !cpu_on_main_clk |=> cpu_clk_enable && !gnd; endproperty
  a_ref: assert property (p_ref) else $error("stop taken on subclock");
  property p_halt; go && cpu_on_main_clk && pend |=> !cpu_clk_enable && main_osc_enable && !gnd;
  endproperty
  a_halt: assert property (p_halt) else $error("no fall to halt");
  property p_sub; sub_osc_enable; endproperty
  a_sub: assert property (p_sub) else $error("subclock stopped");
  property p_per; gnd |-> !(cpu_clk_enable || timer16_run || watchdog_run || adc_run); endproperty
  a_per: assert property (p_per) else $error("peripheral runs");
  property p_int; gnd |-> !ext_irq_zero_enable && ext_irq_one_to_three_enable; endproperty
  a_int: assert property (p_int) else $error("irq enables wrong");
  property p_bus; gnd |-> !mux_addr_data_lines_oe && !addr_latch_strobe && rd_n && wr_n && !wait_oe;
  endproperty
  a_bus: assert property (p_bus) else $error("bus not parked");
  property p_hold; gnd && $past(gnd) |-> $stable(upper_addr_lines) && $stable(port_out); endproperty
  a_hold: assert property (p_hold) else $error("latched lines moved");
  property p_wake; $rose(cpu_clk_enable) |-> ##[0:1] (wake_vector || wake_continue || wake_reset);
  endproperty
  a_wake: assert property (p_wake) else $error("no wake pulse");
  property p_vec; wake_vector |-> cpu_ack_enable; endproperty
  a_vec: assert property (p_vec) else $error("vector without ack");
endmodule

bind ssc_top ssc_properties #(.NIRQ(NIRQ), .PORT_W(PORT_W)) u_props (.*);

// ---- verification/ssc_cpu_model.sv ----
/*
  CPU bus unit model: bus and port values that move every cycle.
  Assumes rnd is a fresh random word each clock.
*/
`timescale 1ns/1ps
module ssc_cpu_model (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic [15:0] rnd,
  output logic      [7:0]  cpu_ad_out,
  output logic             cpu_ad_oe,
  output logic      [7:0]  cpu_upper_addr,
  output logic             cpu_addr_latch_strobe,
  output logic             cpu_rd_n,
  output logic             cpu_wr_n,
  output logic             cpu_wait_oe,
  output logic      [7:0]  cpu_port_latch
);
  // crystal main clock only
  // Changing values make a leaky hold visible
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      {cpu_ad_out, cpu_upper_addr, cpu_port_latch} <= '0;
      {cpu_ad_oe, cpu_addr_latch_strobe, cpu_rd_n, cpu_wr_n, cpu_wait_oe} <= 5'h0c;
    end else begin
      {cpu_ad_out, cpu_upper_addr} <= rnd;
      cpu_port_latch <= rnd[7:0] ^ 8'h5a;
      {cpu_ad_oe, cpu_addr_latch_strobe, cpu_rd_n, cpu_wr_n, cpu_wait_oe} <= rnd[4:0];
    end
  end
endmodule

// ---- verification/test_stop_mode_standby_control.sv ----
/*
  Self-checking bench of the standby controller.
  Assumes shortened settle counts: base 1, reset settle 8.
*/
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin error_cnt++; \
  $display("wrong value at %0t: %h vs %h", $time, a, b); end end
module test_stop_mode_standby_control;
  logic clk = 0, arst_n = 0, avs_read = 0, avs_write = 0, cpu_stop_exec = 0;
  logic cpu_on_main_clk = 1, cpu_ack_enable = 1, test_req = 0, test_mask = 0;
  logic ext_reset_n = 1, sub_clk_present = 1, avs_waitrequest, irq;
  logic cpu_ad_oe, cpu_addr_latch_strobe, cpu_rd_n, cpu_wr_n, cpu_wait_oe, mux_addr_data_lines_oe;
  logic addr_latch_strobe, rd_n, wr_n, wait_oe, main_osc_enable, main_osc_input_ground;
  logic sub_osc_enable, cpu_clk_enable, timer16_run, watchdog_run, adc_run, timer8_run;
  logic watch_timer_run, serial_run, auto_txrx_run, ext_irq_zero_enable;
  logic ext_irq_one_to_three_enable, wake_vector, wake_continue, wake_reset;
  logic [4:0]  avs_address = '0;
  logic [3:0]  avs_byteenable = 4'hf;
  logic [31:0] avs_writedata = '0, avs_readdata;
  logic [7:0]  irq_req = '0, irq_mask = '0, cpu_ad_out, cpu_upper_addr, cpu_port_latch;
  logic [7:0]  mux_addr_data_lines_o, upper_addr_lines, port_out;
  logic [15:0] rnd = 16'h0b91;
  logic [31:0] exp_q[$];
  int error_cnt = 0, check_count = 0;

  ssc_top #(.SETTLE_BASE_LOG2(1), .RST_SETTLE_CYCLES(8)) uut (.*);
  ssc_cpu_model u_cpu (.*);

  always #2.5 clk = ~clk;
  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  always @(posedge clk) rnd <= lfsr(rnd);

  // -------------------------------------------------------------------------
  // Tasks
  // -------------------------------------------------------------------------
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d, e);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    if (!w) exp_q.push_back(e);
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    avs_read <= 0;
    avs_write <= 0;
  endtask
  task automatic stop(input logic m);
    @(posedge clk);
    cpu_on_main_clk <= m;
    cpu_stop_exec <= 1;
    @(posedge clk);
    cpu_stop_exec <= 0;
    cpu_on_main_clk <= 1;
  endtask
  // Counts edges until a wake pulse
  task automatic wake(input logic [2:0] e, input int lo, hi);
    int n;
    n = 0;
    exp_q.push_back({29'h0, e});
    do begin @(posedge clk); n++; end
    while (!(wake_vector | wake_continue | wake_reset) && n < 2000);
    `CHK(n >= lo && n <= hi, 1'b1)
  endtask
  task automatic cmp(input logic [31:0] v);
    logic [31:0] e;
    e = exp_q.size() ? exp_q.pop_front() : 'x;
    `CHK(v, e)
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  always @(posedge clk) begin
    if (avs_read && avs_waitrequest === 1'b0) cmp(avs_readdata);
    if (wake_vector | wake_continue | wake_reset) cmp({29'h0, wake_vector, wake_continue, wake_reset});
  end
  initial begin
    #20000;
    error_cnt++;
    results();
  end

  // -------------------------------------------------------------------------
  // Tests
  // -------------------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clk);
    arst_n <= 1;
    bus(0, 5'h00, 0, 32'h04);
    bus(0, 5'h04, 0, 0);
    bus(0, 5'h08, 0, 32'h21);
    bus(0, 5'h10, 0, 0);
    bus(0, 5'h14, 0, 0);
    $display("test registers done");
    stop(0);
    @(negedge clk) `CHK(cpu_clk_enable, 1'b1)
    `CHK(irq, 1'b0)
    bus(1, 5'h10, 32'h3f, 0);
    @(negedge clk) `CHK(irq, 1'b1)
    bus(0, 5'h0c, 0, 32'h20);
    @(negedge clk) `CHK(irq, 1'b0)
    $display("test refused done");
    bus(1, 5'h00, 7, 0);
    bus(1, 5'h04, 1, 0);
    stop(1);
    bus(0, 5'h08, 0, 32'h22);
    @(negedge clk) `CHK(timer8_run, 1'b1)
    `CHK(watch_timer_run, 1'b0)
    `CHK(serial_run, 1'b0)
    @(posedge clk) irq_req <= 8'h01;
    wake(3'b100, 32, 37);
    irq_req <= 0;
    bus(0, 5'h0c, 0, 32'h05);
    $display("test irq wake done");
    bus(1, 5'h00, 1, 0);
    bus(1, 5'h04, 14, 0);
    stop(1);
    @(negedge clk) `CHK(watch_timer_run, 1'b1)
    `CHK(auto_txrx_run, 1'b0)
    `CHK(serial_run, 1'b1)
    @(posedge clk) test_req <= 1;
    wake(3'b010, 4, 9);
    test_req <= 0;
    bus(0, 5'h0c, 0, 32'h09);
    $display("test test wake done");
    stop(1);
    @(posedge clk) {test_req, test_mask} <= 2'b11;
    repeat (4) @(posedge clk);
    @(negedge clk) `CHK(main_osc_input_ground, 1'b1)
    @(posedge clk) ext_reset_n <= 0;
    repeat (5) @(posedge clk);
    @(negedge clk) `CHK(main_osc_input_ground, 1'b1)
    @(posedge clk) ext_reset_n <= 1;
    wake(3'b001, 8, 15);
    {test_req, test_mask} <= 2'b00;
    bus(0, 5'h0c, 0, 32'h11);
    $display("test reset wake done");
    bus(1, 5'h00, 7, 0);
    @(posedge clk) {irq_req, cpu_ack_enable} <= {8'h02, 1'b0};
    stop(1);
    bus(0, 5'h08, 0, 32'h24);
    wake(3'b010, 1, 40);
    irq_req <= 0;
    $display("test halt done");
    results();
  end
endmodule
